// *** design/pins_pkg.sv ***
/*
 contents: constants, timing counts and carrier structs for the host control pin block.
 assumptions: a single 20 MHz system clock; the beeper and indicator are driven by the host pin block.
*/
package pins_pkg;
	localparam int CLK_HZ = 20000000;
	// wake low window in microseconds
	localparam int WAKE_MIN_US = 100;
	localparam int WAKE_MAX_US = 500;
	localparam int WAKE_MIN_CYC = (WAKE_MIN_US * (CLK_HZ / 1000000));
	localparam int WAKE_MAX_CYC = (WAKE_MAX_US * (CLK_HZ / 1000000));
	// trigger low and rearm high intervals in milliseconds
	localparam int TRIG_LOW_MS = 10;
	localparam int TRIG_HIGH_MS = 10;
	localparam int TRIG_LOW_CYC = TRIG_LOW_MS * (CLK_HZ / 1000);
	localparam int TRIG_HIGH_CYC = TRIG_HIGH_MS * (CLK_HZ / 1000);
	// glitch filter length in cycles
	localparam int FILT_CYC = 4;
	// baud limits in bits per second
	localparam int BAUD_MIN_BPS = 1200;
	localparam int BAUD_MAX_BPS = 115200;
	localparam int BAUD_DIV_W = 16;
	localparam logic [BAUD_DIV_W-1:0] BAUD_DIV_MAX = 16'(CLK_HZ / BAUD_MIN_BPS);
	localparam logic [BAUD_DIV_W-1:0] BAUD_DIV_MIN = 16'(CLK_HZ / BAUD_MAX_BPS);
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

	// configuration carried in from the engine core
	typedef struct packed {
		logic [CNT_W-1:0] good_read_len;
		logic [CNT_W-1:0] beep_len;
		logic [15:0] beep_half_period;
		logic [CNT_W-1:0] scan_timeout;
		logic timeout_en;
		logic [BAUD_DIV_W-1:0] baud_div;
	} pin_cfg_t;

	// events and state reported to the engine core
	typedef struct packed {
		logic restart;
		logic aim_on;
		logic session_active;
		logic session_start;
		logic [BAUD_DIV_W-1:0] baud_div;
	} pin_stat_t;
endpackage

// *** design/pin_filter.sv ***
/*
 contents: three-stage synchroniser and glitch filter for one host pin.
 assumptions: input is asynchronous to clk; output idles high like the pin.
*/
`timescale 1ns/10ps
module pin_filter (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and filtered level
	input wire logic pin,
	output logic level
);
	import pins_pkg::*;
	logic [2:0] sync_r, sync_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic level_r, level_nxt;

	// count agreement of the last two stages before accepting a change
	always_comb begin
		sync_nxt = {sync_r[1:0], pin};
		cnt_nxt = cnt_r;
		level_nxt = level_r;
		if ((sync_r[1] == sync_r[2]) && (sync_r[2] != level_r)) begin
			if (cnt_r == 3'(FILT_CYC - 1)) begin
				level_nxt = sync_r[2];
				cnt_nxt = 3'h0;
			end else begin
				cnt_nxt = cnt_r + 3'h1;
			end
		end else begin
			cnt_nxt = 3'h0;
		end
	end

	// register stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_r <= 3'h7;
			cnt_r <= 3'h0;
			level_r <= 1'b1;
		end else begin
			sync_r <= sync_nxt;
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
endmodule

// *** design/host_pins.sv ***
/*
 contents: host control pin logic: wake/aim, trigger sessions, beeper pwm, good-read indicator.
 assumptions: engine core supplies low-power state, decode results and configuration.
*/
// Operation
// - low 100-500us then high restarts device in low power
// - held trigger low starts scan session
// - level mode scans after 10ms low
// - timeout ends session despite low trigger
// - rearm only after 10ms trigger high
// - pwm beeper output for audible events
// - good read raises indicator fixed time
// - serial baud 1200 to 115200 bps
// - wake pin aims unless low power
`timescale 1ns/10ps
module host_pins (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host pins
	input wire logic aim_or_wakeup_input,
	input wire logic trigger_n,
	output logic audible_pwm_output,
	output logic good_read_indicator,
	// engine core side
	input wire logic low_power,
	input wire logic decode_ok,
	input wire logic decode_done,
	input wire logic beep_req,
	input wire pins_pkg::pin_cfg_t cfg,
	output pins_pkg::pin_stat_t stat
);
	import pins_pkg::*;

	typedef enum logic [3:0] {
		TS_ARM = 4'b0001,
		TS_WAIT = 4'b0010,
		TS_SCAN = 4'b0100,
		TS_REARM = 4'b1000
	} trig_state_t;

	logic wake_lvl, trig_lvl;

	// filtered copies of the two host inputs
	pin_filter u_wake (
		.clk(clk),
		.rst_n(rst_n),
		.pin(aim_or_wakeup_input),
		.level(wake_lvl)
	);
	pin_filter u_trig (
		.clk(clk),
		.rst_n(rst_n),
		.pin(trigger_n),
		.level(trig_lvl)
	);

	// saturating increment shared by the wake and trigger counters
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == {CNT_W{1'b1}}) ? v : v + CNT_ONE;
	endfunction

	// wake pulse measurement
	logic [CNT_W-1:0] wcnt_r, wcnt_nxt;
	logic wprev_r, wprev_nxt;
	logic restart_r, restart_nxt;
	logic aim_r, aim_nxt;
	always_comb begin
		wprev_nxt = wake_lvl;
		wcnt_nxt = wcnt_r;
		restart_nxt = 1'b0;
		aim_nxt = !low_power && !wake_lvl;
		if (!wake_lvl) begin
			wcnt_nxt = sat_inc(wcnt_r);
		end else begin
			wcnt_nxt = CNT_ZERO;
			if (!wprev_r && low_power && (wcnt_r >= CNT_W'(WAKE_MIN_CYC))
				&& (wcnt_r <= CNT_W'(WAKE_MAX_CYC))) begin
				restart_nxt = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wcnt_r <= CNT_ZERO;
			wprev_r <= 1'b1;
			restart_r <= 1'b0;
			aim_r <= 1'b0;
		end else begin
			wcnt_r <= wcnt_nxt;
			wprev_r <= wprev_nxt;
			restart_r <= restart_nxt;
			aim_r <= aim_nxt;
		end
	end

	// trigger session state machine
	trig_state_t ts_r, ts_nxt;
	logic [CNT_W-1:0] tcnt_r, tcnt_nxt;
	logic start_r, start_nxt;
	logic act_r, act_nxt;
	always_comb begin
		ts_nxt = ts_r;
		tcnt_nxt = tcnt_r;
		start_nxt = 1'b0;
		unique case (ts_r)
			TS_ARM: begin
				tcnt_nxt = CNT_ZERO;
				if (!trig_lvl) begin
					ts_nxt = TS_WAIT;
				end
			end
			TS_WAIT: begin
				if (trig_lvl) begin
					ts_nxt = TS_ARM;
				end else if (tcnt_r >= CNT_W'(TRIG_LOW_CYC - 1)) begin
					ts_nxt = TS_SCAN;
					start_nxt = 1'b1;
					tcnt_nxt = CNT_ZERO;
				end else begin
					tcnt_nxt = sat_inc(tcnt_r);
				end
			end
			TS_SCAN: begin
				tcnt_nxt = sat_inc(tcnt_r);
				if (decode_done || trig_lvl
					|| (cfg.timeout_en && (tcnt_r >= cfg.scan_timeout))) begin
					ts_nxt = TS_REARM;
					tcnt_nxt = CNT_ZERO;
				end
			end
			TS_REARM: begin
				if (!trig_lvl) begin
					tcnt_nxt = CNT_ZERO;
				end else if (tcnt_r >= CNT_W'(TRIG_HIGH_CYC - 1)) begin
					ts_nxt = TS_ARM;
				end else begin
					tcnt_nxt = sat_inc(tcnt_r);
				end
			end
			default: begin
				ts_nxt = TS_REARM;
				tcnt_nxt = CNT_ZERO;
			end
		endcase
		// session flag registered together with the state so the port comes from a flop
		act_nxt = (ts_nxt == TS_SCAN);
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ts_r <= TS_REARM;
			tcnt_r <= CNT_ZERO;
			start_r <= 1'b0;
			act_r <= 1'b0;
		end else begin
			ts_r <= ts_nxt;
			tcnt_r <= tcnt_nxt;
			start_r <= start_nxt;
			act_r <= act_nxt;
		end
	end

	// good read indicator, high for the configured length
	logic [CNT_W-1:0] gcnt_r, gcnt_nxt;
	logic good_r, good_nxt;
	always_comb begin
		gcnt_nxt = gcnt_r;
		good_nxt = good_r;
		if (decode_ok && (cfg.good_read_len != CNT_ZERO)) begin
			gcnt_nxt = cfg.good_read_len - CNT_ONE;
			good_nxt = 1'b1;
		end else if (gcnt_r != CNT_ZERO) begin
			gcnt_nxt = gcnt_r - CNT_ONE;
		end else begin
			good_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gcnt_r <= CNT_ZERO;
			good_r <= 1'b0;
		end else begin
			gcnt_r <= gcnt_nxt;
			good_r <= good_nxt;
		end
	end

	// beeper: square wave for the configured length, also after reset
	logic [CNT_W-1:0] bcnt_r, bcnt_nxt;
	logic [15:0] bph_r, bph_nxt;
	logic pwm_r, pwm_nxt;
	logic pwr_r, pwr_nxt;
	always_comb begin
		bcnt_nxt = bcnt_r;
		bph_nxt = bph_r;
		pwm_nxt = 1'b0;
		pwr_nxt = 1'b0;
		if (beep_req || pwr_r || decode_ok) begin
			bcnt_nxt = cfg.beep_len;
			bph_nxt = 16'h0000;
		end else if (bcnt_r != CNT_ZERO) begin
			bcnt_nxt = bcnt_r - CNT_ONE;
			pwm_nxt = pwm_r;
			if (bph_r >= cfg.beep_half_period) begin
				bph_nxt = 16'h0000;
				pwm_nxt = !pwm_r;
			end else begin
				bph_nxt = bph_r + 16'h0001;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bcnt_r <= CNT_ZERO;
			bph_r <= 16'h0000;
			pwm_r <= 1'b0;
			pwr_r <= 1'b1;
		end else begin
			bcnt_r <= bcnt_nxt;
			bph_r <= bph_nxt;
			pwm_r <= pwm_nxt;
			pwr_r <= pwr_nxt;
		end
	end

	// serial divisor clamped to the supported baud range
	logic [BAUD_DIV_W-1:0] div_r, div_nxt;
	always_comb begin
		div_nxt = cfg.baud_div;
		if (cfg.baud_div > BAUD_DIV_MAX) begin
			div_nxt = BAUD_DIV_MAX;
		end else if (cfg.baud_div < BAUD_DIV_MIN) begin
			div_nxt = BAUD_DIV_MIN;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= BAUD_DIV_MAX;
		end else begin
			div_r <= div_nxt;
		end
	end

	assign audible_pwm_output = pwm_r;
	assign good_read_indicator = good_r;
	assign stat = '{restart: restart_r, aim_on: aim_r, session_active: act_r,
		session_start: start_r, baud_div: div_r};
endmodule

// *** testbench/host_pins_props.sv ***
/*
 checker on host_pins ports.
 assumes bind from the bench top; cfg.beep_half_period and cfg.good_read_len above zero.
*/
`timescale 1ns/10ps
module host_pins_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and core side
	input wire logic trigger_n,
	input wire logic audible_pwm_output,
	input wire logic good_read_indicator,
	input wire logic low_power,
	input wire logic decode_ok,
	input wire logic beep_req,
	input wire pins_pkg::pin_stat_t stat
);
	import pins_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// indicator rises only for a decode
	chk_gr_rise: assert property (decode_ok |=> good_read_indicator)
		else $error("indicator not raised");
	chk_gr_cause: assert property ($rose(good_read_indicator) |-> $past(decode_ok))
		else $error("indicator rose alone");
	chk_baud_range: assert property (stat.baud_div inside {[BAUD_DIV_MIN:BAUD_DIV_MAX]})
		else $error("divider out of range");
	// restart is one cycle and only in low power
	chk_restart_pulse: assert property (stat.restart |=> !stat.restart)
		else $error("restart too long");
	chk_restart_lp: assert property (stat.restart |-> $past(low_power))
		else $error("restart outside low power");
	// the pin was low before the filter latency ran out
	chk_start_low: assert property (stat.session_start |-> !$past(trigger_n, 8))
		else $error("session with trigger high");
	chk_start_active: assert property (stat.session_start |-> stat.session_active ##1 !stat.session_start)
		else $error("session start bad");
	// a new beep may restart the wave at any time
	chk_pwm_hold: assert property ($changed(audible_pwm_output) && !beep_req && !decode_ok
		|=> $stable(audible_pwm_output))
		else $error("pwm toggles too fast");
endmodule

// *** testbench/host_drv.sv ***
/*
 host model driving wake and trigger pins.
 assumes the bench calls its tasks; pins move on falling edges.
*/
`timescale 1ns/10ps
module host_drv (
	// clock
	input wire logic clk,
	// pins toward the engine
	output logic wake,
	output logic trig_n
);
	localparam int GAP_CYC = 200; // restart spacing, shortened from two seconds
	// pins idle high
	initial begin
		wake = 1'b1;
		trig_n = 1'b1;
	end
	task automatic hold_trig(input logic v);
		@(negedge clk);
		trig_n = v;
	endtask
	task automatic hold_wake(input logic v);
		@(negedge clk);
		wake = v;
	endtask
	// quiet gap, then low for n cycles, then high
	task automatic wake_pulse(input int n);
		repeat (GAP_CYC) @(negedge clk);
		hold_wake(1'b0);
		repeat (n) @(negedge clk);
		wake = 1'b1;
	endtask
endmodule

// *** testbench/tb_host_pins.sv ***
/*
 self-checking bench for host_pins.
 assumes host_drv drives the pins; all inputs move on falling edges.
*/
`timescale 1ns/10ps
module tb_host_pins;
	import pins_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, low_power = 1'b0, decode_ok = 1'b0, decode_done = 1'b0;
	logic beep_req = 1'b0;
	logic wake, trig_n, pwm, gri;
	pin_cfg_t cfg;
	pin_stat_t stat;
	int n_fail = 0, comparisons = 0, cyc = 0;
	// clock at 20 MHz
	always #25 clk = ~clk;
	host_drv i_host (.clk(clk), .wake(wake), .trig_n(trig_n));
	host_pins i_dut (.clk(clk), .rst_n(rst_n), .aim_or_wakeup_input(wake), .trigger_n(trig_n),
		.audible_pwm_output(pwm), .good_read_indicator(gri), .low_power(low_power),
		.decode_ok(decode_ok), .decode_done(decode_done), .beep_req(beep_req), .cfg(cfg),
		.stat(stat));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang limit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic t_baud(input logic [15:0] v, input logic [15:0] exp);
		cfg.baud_div = v;
		repeat (3) @(negedge clk);
		chk(stat.baud_div, exp);
	endtask
	task automatic t_wake(input int w, input logic lp, input int exp);
		int n;
		n = 0;
		low_power = lp;
		i_host.wake_pulse(w);
		repeat (40) begin
			@(negedge clk);
			if (stat.restart === 1'b1)
				n++;
		end
		chk(n, exp);
	endtask
	task automatic t_aim();
		low_power = 1'b0;
		i_host.hold_wake(1'b0);
		repeat (20) @(negedge clk);
		chk(stat.aim_on, 1);
		i_host.hold_wake(1'b1);
		repeat (20) @(negedge clk);
		chk(stat.aim_on, 0);
	endtask
	// trigger during the rearm time after reset must be refused
	task automatic t_trig();
		int n;
		n = 0;
		i_host.hold_trig(1'b0);
		repeat (300) begin
			@(negedge clk);
			if (stat.session_start === 1'b1 || stat.session_active === 1'b1)
				n++;
		end
		chk(n, 0);
		i_host.hold_trig(1'b1);
		repeat (20) @(negedge clk);
		chk(stat.session_active, 0);
	endtask
	task automatic t_good();
		int n;
		n = 0;
		chk(gri, 0);
		decode_ok = 1'b1;
		@(negedge clk);
		decode_ok = 1'b0;
		// the first high cycle is already visible at this edge
		repeat (40) begin
			if (gri === 1'b1)
				n++;
			@(negedge clk);
		end
		chk(n, 16);
	endtask
	task automatic t_beep();
		logic p;
		int k;
		beep_req = 1'b1;
		@(negedge clk);
		beep_req = 1'b0;
		for (int i = 0; i < 2; i++) begin
			p = pwm;
			k = 0;
			while (pwm === p && k < 50) begin
				@(negedge clk);
				k++;
			end
		end
		chk(k, 4);
	endtask
	// main sequence
	initial begin
		cfg = '0;
		cfg.good_read_len = 24'h000010;
		cfg.beep_len = 24'h000028;
		cfg.beep_half_period = 16'h0003;
		repeat (12) @(negedge clk);
		chk(stat.baud_div, BAUD_DIV_MAX);
		rst_n = 1'b1;
		t_baud(16'h0000, BAUD_DIV_MIN);
		t_baud(16'hffff, BAUD_DIV_MAX);
		t_baud(16'h1000, 16'h1000);
		t_wake(1900, 1'b1, 0);
		t_wake(2100, 1'b1, 1);
		t_wake(9900, 1'b1, 1);
		t_wake(10200, 1'b1, 0);
		t_wake(2100, 1'b0, 0);
		t_aim();
		t_trig();
		t_good();
		t_beep();
		give_verdict();
	end
endmodule
bind host_pins host_pins_props i_props (.clk(clk), .rst_n(rst_n), .trigger_n(trigger_n),
	.audible_pwm_output(audible_pwm_output), .good_read_indicator(good_read_indicator),
	.low_power(low_power), .decode_ok(decode_ok), .beep_req(beep_req), .stat(stat));
